// ### hw/core_pc_stack_status_indirect_regs.sv
// counter, stack, status, working shadow and indirect registers of the core
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module core_pc_stack_status_indirect_regs
  import core_sfr_pkg::*;
#(
  parameter int unsigned STACK_AW = SP_W
) (
  // clock, power-on/brown-out reset, other resets
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              soft_rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // core events
  input  wire logic              ret_i,
  input  wire logic              watchdog_clear_instr_i,
  input  wire logic              sleep_i,
  input  wire logic              wdt_timeout_i,
  input  wire alu_op_e           alu_op_i,
  input  wire logic [7:0]        alu_a_i,
  input  wire logic [7:0]        alu_b_i,
  // state seen by the core
  output logic      [PC_W-1:0]   pc_o,
  output logic      [PC_W-1:0]   tos_o,
  output logic      [7:0]        status_o,
  output logic      [7:0]        working_reg_shadow_o,
  output logic      [SP_W-1:0]   stack_location_pointer_o
);
  // the pointer field is exactly five bits wide
  if (STACK_AW != SP_W) begin : g_bad_aw
    $error("STACK_AW must equal the 5-bit stack pointer width");
  end

  logic [PC_W-1:0]   pc_q, pc_d;
  logic [4:0]        latu_q, latu_d;
  logic [7:0]        lath_q, lath_d;
  logic [SP_W-1:0]   sp_q, sp_d;
  logic [7:0]        status_q, status_d;
  logic [7:0]        working_reg_shadow_q;
  logic [7:0]        rdata_q, rmux;
  logic [ADDR_W-1:0] ptr_q [N_IND];
  logic [ADDR_W-1:0] ptr_d [N_IND];
  logic [N_IND-1:0]  hit_plain, hit_dec, hit_inc, hit_any, eff_ind;
  logic [N_IND-1:0]  wr_ptr_lo, wr_ptr_hi, step_inc, step_dec;
  logic [PC_W-1:0]   stack_top_value;
  logic [PC_W-1:0]   tos_new;
  // declared ahead of the pointer decode, which reads them
  logic              acc_null, acc_wr, acc_rd;

  stack_mem_if #(.WIDTH(PC_W), .AW(STACK_AW)) smif ();

  stack_mem #(.WIDTH(PC_W), .AW(STACK_AW)) u_stack (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .port   (smif.mem)
  );

  // indirect channel decode and pointer storage
  for (genvar i = 0; i < N_IND; i++) begin : g_ind
    assign hit_plain[i] = (addr_i == OFS_INDF[i]);
    assign hit_dec[i]   = (addr_i == OFS_POSTDEC[i]);
    assign hit_inc[i]   = (addr_i == OFS_POSTINC[i]);
    assign hit_any[i]   = hit_plain[i] | hit_dec[i] | hit_inc[i];
    assign step_inc[i]  = hit_inc[i] & (rd_i | wr_i);
    assign step_dec[i]  = hit_dec[i] & (rd_i | wr_i);

    // post steps override a byte write to the same pointer
    always_comb begin
      ptr_d[i] = ptr_q[i];
      if (wr_ptr_lo[i]) begin
        ptr_d[i][7:0] = wdata_i;
      end
      if (wr_ptr_hi[i]) begin
        ptr_d[i][11:8] = wdata_i[3:0];
      end
      if (step_inc[i]) begin
        ptr_d[i] = ptr_q[i] + 12'h001;
      end else if (step_dec[i]) begin
        ptr_d[i] = ptr_q[i] - 12'h001;
      end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        ptr_q[i] <= PTR_RST;
      end else if (soft_rst_i) begin
        ptr_q[i] <= PTR_RST;
      end else begin
        ptr_q[i] <= ptr_d[i];
      end
    end
  end

  // effective address: the pointer value before any post step
  wire [ADDR_W-1:0] ind_ptr  = hit_any[0] ? ptr_q[0] : (hit_any[1] ? ptr_q[1] : ptr_q[2]);
  wire [ADDR_W-1:0] eff_addr = (|hit_any) ? ind_ptr : addr_i;

  // an indirect access aimed at an indirect register reads and writes nothing, but a post step still moves its pointer
  for (genvar i = 0; i < N_IND; i++) begin : g_self
    assign eff_ind[i] = (eff_addr == OFS_INDF[i]) | (eff_addr == OFS_POSTDEC[i])
                      | (eff_addr == OFS_POSTINC[i]);
    assign wr_ptr_lo[i] = acc_wr & (eff_addr == OFS_PTR_LO[i]);
    assign wr_ptr_hi[i] = acc_wr & (eff_addr == OFS_PTR_HI[i]);
  end

  assign acc_null = (|hit_any) & (|eff_ind);
  assign acc_wr   = wr_i & ~acc_null;
  assign acc_rd   = rd_i & ~acc_null;

  // write and read strobes per register
  wire wr_pcl    = acc_wr & (eff_addr == OFS_PCL);
  wire rd_pcl    = acc_rd & (eff_addr == OFS_PCL);
  wire wr_lat_l  = acc_wr & (eff_addr == OFS_PROG_COUNTER_LATCHES_L);
  wire wr_lat_h  = acc_wr & (eff_addr == OFS_PROG_COUNTER_LATCHES_H);
  wire wr_sp     = acc_wr & (eff_addr == OFS_STACK_LOCATION_POINTER);
  wire wr_tos_l  = acc_wr & (eff_addr == OFS_TOS_L);
  wire wr_tos_h  = acc_wr & (eff_addr == OFS_TOS_H);
  wire wr_tos_u  = acc_wr & (eff_addr == OFS_TOS_U);
  wire wr_status = acc_wr & (eff_addr == OFS_STATUS);
  wire wr_working_reg_shadow   = acc_wr & (eff_addr == OFS_WORKING_REG_SHADOW);

  // read multiplexer; unmapped and reserved bits read zero
  always_comb begin
    rmux = 8'h00;
    case (eff_addr)
      OFS_STATUS:     rmux = {1'b0, status_q[6:0]};
      OFS_WORKING_REG_SHADOW:       rmux = working_reg_shadow_q;
      OFS_PCL:        rmux = pc_q[7:0];
      OFS_PROG_COUNTER_LATCHES_L:    rmux = lath_q;
      OFS_PROG_COUNTER_LATCHES_H:    rmux = {3'h0, latu_q};
      OFS_STACK_LOCATION_POINTER:     rmux = {3'h0, sp_q};
      OFS_TOS_L:      rmux = stack_top_value[7:0];
      OFS_TOS_H:      rmux = stack_top_value[15:8];
      OFS_TOS_U:      rmux = {3'h0, stack_top_value[20:16]};
      OFS_PTR_LO[0]:  rmux = ptr_q[0][7:0];
      OFS_PTR_HI[0]:  rmux = {4'h0, ptr_q[0][11:8]};
      OFS_PTR_LO[1]:  rmux = ptr_q[1][7:0];
      OFS_PTR_HI[1]:  rmux = {4'h0, ptr_q[1][11:8]};
      OFS_PTR_LO[2]:  rmux = ptr_q[2][7:0];
      OFS_PTR_HI[2]:  rmux = {4'h0, ptr_q[2][11:8]};
      default:        rmux = 8'h00;
    endcase
  end

  // read data stand for exactly one cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= acc_rd ? rmux : 8'h00;
    end
  end

  // program counter: return beats a software write in the same cycle
  always_comb begin
    pc_d = pc_q;
    if (soft_rst_i) begin
      pc_d = '0;
    end else if (ret_i) begin
      pc_d = stack_top_value;
    end else if (wr_pcl) begin
      pc_d = {latu_q, lath_q, wdata_i};
    end
  end

  // latches capture the live counter on a low-byte read
  always_comb begin
    latu_d = latu_q;
    lath_d = lath_q;
    if (soft_rst_i) begin
      latu_d = 5'h00;
      lath_d = 8'h00;
    end else if (rd_pcl) begin
      latu_d = pc_q[PC_UP_LSB +: 5];
      lath_d = pc_q[PC_HI_LSB +: 8];
    end else begin
      if (wr_lat_l) begin
        lath_d = wdata_i;
      end
      if (wr_lat_h) begin
        latu_d = wdata_i[4:0];
      end
    end
  end

  assign sp_d = soft_rst_i ? '0 : (wr_sp ? wdata_i[SP_W-1:0] : sp_q);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc_q   <= '0;
      latu_q <= 5'h00;
      lath_q <= 8'h00;
      sp_q   <= '0;
    end else begin
      pc_q   <= pc_d;
      latu_q <= latu_d;
      lath_q <= lath_d;
      sp_q   <= sp_d;
    end
  end

  // stack top: memory is read at the next pointer so the view never lags
  assign stack_top_value = smif.rd_data;
  assign tos_new = wr_tos_l ? {stack_top_value[20:8], wdata_i}
                 : (wr_tos_h ? {stack_top_value[20:16], wdata_i, stack_top_value[7:0]}
                 : {wdata_i[4:0], stack_top_value[15:0]});
  assign smif.rd_addr = sp_d;
  assign smif.wr_en   = wr_tos_l | wr_tos_h | wr_tos_u;
  assign smif.wr_addr = sp_q;
  assign smif.wr_data = tos_new;

  // alu flag arithmetic; subtract adds the complement plus one
  wire       is_sub  = (alu_op_i == ALU_SUB);
  wire       is_arith = (alu_op_i == ALU_ADD) | is_sub;
  wire [7:0] opnd_b  = is_sub ? ~alu_b_i : alu_b_i;
  wire [8:0] sum9    = {1'b0, alu_a_i} + {1'b0, opnd_b} + {8'h00, is_sub};
  wire [4:0] low5    = {1'b0, alu_a_i[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, is_sub};
  wire [7:0] rot_l   = {alu_a_i[6:0], status_q[BIT_C]};
  wire [7:0] rot_r   = {status_q[BIT_C], alu_a_i[7:1]};
  wire [7:0] result  = is_arith ? sum9[7:0]
                     : ((alu_op_i == ALU_RLC) ? rot_l
                     : ((alu_op_i == ALU_RRC) ? rot_r : alu_a_i));
  wire       ov      = (alu_a_i[7] == opnd_b[7]) & (sum9[7] != alu_a_i[7]);
  wire       upd_nz  = (alu_op_i != ALU_NONE);

  // status: hardware updates win over a software write in the same cycle
  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d[4:0] = wdata_i[4:0];
    end
    if (upd_nz) begin
      status_d[BIT_N] = result[7];
      status_d[BIT_Z] = (result == 8'h00);
    end
    if (is_arith) begin
      status_d[BIT_OV] = ov;
      status_d[BIT_DC] = low5[4];
      status_d[BIT_C]  = sum9[8];
    end
    if (alu_op_i == ALU_RLC) begin
      status_d[BIT_C] = alu_a_i[7];
    end
    if (alu_op_i == ALU_RRC) begin
      status_d[BIT_C] = alu_a_i[0];
    end
    if (watchdog_clear_instr_i | sleep_i) begin
      status_d[BIT_TO] = 1'b1;
    end
    if (wdt_timeout_i) begin
      status_d[BIT_TO] = 1'b0;
    end
    if (watchdog_clear_instr_i) begin
      status_d[BIT_PD] = 1'b1;
    end
    if (sleep_i) begin
      status_d[BIT_PD] = 1'b0;
    end
    status_d[7] = 1'b0;
  end

  // flags keep their value over the other resets, only power-on sets them
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_q <= STATUS_RST;
      working_reg_shadow_q   <= WORKING_REG_SHADOW_RST;
    end else begin
      status_q <= status_d;
      working_reg_shadow_q   <= wr_working_reg_shadow ? wdata_i : working_reg_shadow_q;
    end
  end

  assign rdata_o  = rdata_q;
  assign pc_o     = pc_q;
  assign tos_o    = smif.rd_data;
  assign status_o = status_q;
  assign working_reg_shadow_o   = working_reg_shadow_q;
  assign stack_location_pointer_o = sp_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  wire quiet = ~soft_rst_i & ~ret_i;

  sequence s_tos_write;
    wr_i && addr_i == OFS_TOS_L && quiet;
  endsequence
  sequence s_tos_read;
    rd_i && addr_i == OFS_TOS_L && !soft_rst_i;
  endsequence

  chk_pcl_read_latch: assert property (
    (rd_i && addr_i == OFS_PCL && !soft_rst_i) |=>
      (latu_q == $past(pc_q[20:16])) && (lath_q == $past(pc_q[15:8])) &&
      (rdata_o == $past(pc_q[7:0])))
    else $error("low byte read did not capture counter");

  chk_pcl_write_load: assert property (
    (wr_i && addr_i == OFS_PCL && quiet) |=>
      pc_o == {$past(latu_q), $past(lath_q), $past(wdata_i)})
    else $error("low byte write did not load counter");

  chk_ret_load_top: assert property (
    (ret_i && !soft_rst_i) |=> pc_o == $past(tos_o))
    else $error("return did not load stack top");

  chk_tos_write_back: assert property (
    (s_tos_write ##1 s_tos_read) |=> rdata_o == $past(wdata_i, 2))
    else $error("stack top byte did not read back");

  chk_to_timeout: assert property (
    wdt_timeout_i |=> !status_o[BIT_TO] ##1
      (status_o[BIT_TO] || !$past(watchdog_clear_instr_i | sleep_i) || $past(wdt_timeout_i)))
    else $error("time-out flag wrong after watchdog events");

  chk_pd_sleep: assert property (
    (sleep_i && !watchdog_clear_instr_i) |=> !status_o[BIT_PD])
    else $error("power-down flag not cleared by sleep");

  chk_add_flags: assert property (
    (alu_op_i == ALU_ADD) |=>
      status_o[BIT_C] == ($past(alu_a_i) > (8'hFF - $past(alu_b_i))) &&
      status_o[BIT_Z] == (8'($past(alu_a_i) + $past(alu_b_i)) == 8'h00))
    else $error("add flags wrong");

  chk_sub_borrow: assert property (
    (alu_op_i == ALU_SUB) |=> status_o[BIT_C] == ($past(alu_a_i) >= $past(alu_b_i)))
    else $error("subtract carry is not inverted borrow");

  chk_rot_carry: assert property (
    (alu_op_i == ALU_RLC) |=> status_o[BIT_C] == $past(alu_a_i[7]))
    else $error("rotate left did not load carry");

  chk_ind_keep_ptr: assert property (
    (hit_plain[0] && (rd_i || wr_i) && !soft_rst_i &&
     !(wr_i && (ptr_q[0] == OFS_PTR_LO[0] || ptr_q[0] == OFS_PTR_HI[0]))) |=>
      $stable(ptr_q[0]))
    else $error("plain indirect access moved the pointer");

  chk_postinc_step: assert property (
    (hit_inc[1] && (rd_i || wr_i) && !soft_rst_i) |=> ptr_q[1] == $past(ptr_q[1]) + 12'h001)
    else $error("post-increment pointer step wrong");

  chk_postdec_step: assert property (
    (hit_dec[2] && (rd_i || wr_i) && !soft_rst_i) |=> ptr_q[2] == $past(ptr_q[2]) - 12'h001)
    else $error("post-decrement pointer step wrong");
endmodule
`default_nettype wire

// ### hw/core_sfr_pkg.sv
// constants, offsets and field layout of the core special-function registers
// Functional notes
// - reading the counter low byte copies counter upper and high parts into the latches
// - writing the counter low byte loads the counter from latches plus written byte
// - counter low byte is read/write access to counter bits 7:0, resets zero
// - latch register: upper field bits 12:8, high field bits 7:0, both reset zero
// - stack top shows entry chosen by stack pointer; return loads it into counter
// - stack top is read/write, resets zero, upper/high/low fields as laid out; a non-power reset keeps the entries and shows entry 0
// - stack pointer bits 4:0 select the stack entry shown at stack top
// - time-out flag bit 6: set by power-up, watchdog clear, sleep; cleared by time-out
// - power-down flag bit 5: set by power-up, watchdog clear; cleared by sleep
// - negative flag bit 4 is result msb; arithmetic flags survive non-power resets
// - overflow flag bit 3 set when signed result changes sign bit 7
// - zero flag bit 2 set when result is zero, cleared otherwise
// - digit carry bit 1 is carry out of bit 3 on add and subtract
// - carry bit 0 is carry out of msb; on subtract both carries mean no borrow
// - rotate through carry loads carry with source msb or lsb by direction
// - working register shadow is an 8-bit read/write register
// - plain indirect registers act on pointer-addressed register, pointer unchanged
// - post-decrement indirect registers access then decrement the pointer
// - post-increment indirect registers access then increment the pointer
// - each pointer is a 12-bit address: high field 11:8, low byte 7:0
package core_sfr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W   = 21;
  localparam int unsigned SP_W   = 5;
  localparam int unsigned N_IND  = 3;

  // register offsets in data memory
  localparam logic [11:0] OFS_STATUS  = 12'hFD8;
  localparam logic [11:0] OFS_WORKING_REG_SHADOW    = 12'hFE8;
  localparam logic [11:0] OFS_PCL     = 12'hFF9;
  localparam logic [11:0] OFS_PROG_COUNTER_LATCHES_L = 12'hFFA;
  localparam logic [11:0] OFS_PROG_COUNTER_LATCHES_H = 12'hFFB;
  localparam logic [11:0] OFS_STACK_LOCATION_POINTER  = 12'hFFC;
  localparam logic [11:0] OFS_TOS_L   = 12'hFFD;
  localparam logic [11:0] OFS_TOS_H   = 12'hFFE;
  localparam logic [11:0] OFS_TOS_U   = 12'hFFF;
  // per indirect channel 0..2
  localparam logic [11:0] OFS_INDF [3]   = '{12'hFEF, 12'hFE7, 12'hFDF};
  localparam logic [11:0] OFS_POSTDEC [3] = '{12'hFED, 12'hFE5, 12'hFDD};
  localparam logic [11:0] OFS_POSTINC [3] = '{12'hFEE, 12'hFE6, 12'hFDE};
  localparam logic [11:0] OFS_PTR_LO [3]  = '{12'hFE9, 12'hFE1, 12'hFD9};
  localparam logic [11:0] OFS_PTR_HI [3]  = '{12'hFEA, 12'hFE2, 12'hFDA};

  // status bit positions
  localparam int unsigned BIT_TO = 6;
  localparam int unsigned BIT_PD = 5;
  localparam int unsigned BIT_N  = 4;
  localparam int unsigned BIT_OV = 3;
  localparam int unsigned BIT_Z  = 2;
  localparam int unsigned BIT_DC = 1;
  localparam int unsigned BIT_C  = 0;

  // counter field positions
  localparam int unsigned PC_UP_LSB = 16;
  localparam int unsigned PC_HI_LSB = 8;

  // reset values
  localparam logic [7:0]  STATUS_RST = 8'h60;
  localparam logic [7:0]  WORKING_REG_SHADOW_RST   = 8'h00;
  localparam logic [11:0] PTR_RST    = 12'h000;

  // alu operation reported by the core, one-hot
  typedef enum logic [5:0] {
    ALU_NONE  = 6'h01,
    ALU_ADD   = 6'h02,
    ALU_SUB   = 6'h04,
    ALU_LOGIC = 6'h08,
    ALU_RLC   = 6'h10,
    ALU_RRC   = 6'h20
  } alu_op_e;
endpackage

// ### hw/stack_mem_if.sv
// carrier between the register block and the return-stack memory
`timescale 1ns/1ns
`default_nettype none
interface stack_mem_if #(
  parameter int unsigned WIDTH = 21,
  parameter int unsigned AW    = 5
);
  logic [AW-1:0]    rd_addr;
  logic             wr_en;
  logic [AW-1:0]    wr_addr;
  logic [WIDTH-1:0] wr_data;
  logic [WIDTH-1:0] rd_data;

  modport ctrl (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport mem  (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface
`default_nettype wire

// ### hw/stack_mem.sv
// return-stack memory with registered read data and write-through
`timescale 1ns/1ns
`default_nettype none
module stack_mem #(
  parameter int unsigned WIDTH = 21,
  parameter int unsigned AW    = 5
) (
  // clock and power-on reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // memory port
  stack_mem_if.mem  port
);
  localparam int unsigned DEPTH = 1 << AW;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_q;

  // array clears on power-on so every entry reads zero until written
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (port.wr_en) begin
      mem_q[port.wr_addr] <= port.wr_data;
    end
  end

  // write-through keeps the top value current in the cycle after a write
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_q <= '0;
    end else if (port.wr_en && (port.wr_addr == port.rd_addr)) begin
      rd_q <= port.wr_data;
    end else begin
      rd_q <= mem_q[port.rd_addr];
    end
  end

  assign port.rd_data = rd_q;
endmodule
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the counter, stack, status and indirect register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
  import core_sfr_pkg::*;
  // design inputs
  logic              clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              soft_rst_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic              ret_i = 1'b0;
  logic              watchdog_clear_instr_i = 1'b0;
  logic              sleep_i = 1'b0;
  logic              wdt_timeout_i = 1'b0;
  alu_op_e           alu_op_i = ALU_NONE;
  logic [7:0]        alu_a_i = '0;
  logic [7:0]        alu_b_i = '0;
  // design outputs
  logic [DATA_W-1:0] rdata_o;
  logic [PC_W-1:0]   pc_o;
  logic [PC_W-1:0]   tos_o;
  logic [7:0]        status_o;
  logic [7:0]        working_reg_shadow_o;
  logic [SP_W-1:0]   stack_location_pointer_o;
  // bench state
  int                n_errors = 0;
  int                checks = 0;
  logic [31:0]       rs = 32'd26700;
  logic [7:0]        st;
  logic [7:0]        d;
  logic [7:0]        w;
  logic [20:0]       t;
  logic [20:0]       t0;
  alu_op_e           ops [5] = '{ALU_ADD, ALU_SUB, ALU_LOGIC, ALU_RLC, ALU_RRC};

  core_pc_stack_status_indirect_regs #(.STACK_AW(5)) uut (
    .clk_i(clk_i), .nrst_i(nrst_i), .soft_rst_i(soft_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ret_i(ret_i),
    .watchdog_clear_instr_i(watchdog_clear_instr_i), .sleep_i(sleep_i), .wdt_timeout_i(wdt_timeout_i),
    .alu_op_i(alu_op_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .pc_o(pc_o),
    .tos_o(tos_o), .status_o(status_o), .working_reg_shadow_o(working_reg_shadow_o), .stack_location_pointer_o(stack_location_pointer_o));

  // 25 MHz core clock
  always #20 clk_i = ~clk_i;

  // repeatable pseudo-random source
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // expected status after one cycle of core events
  function automatic logic [7:0] nxt(input logic [7:0] s, input logic cw, sl, wt,
                                     input alu_op_e op, input logic [7:0] a, b);
    logic [8:0] sum;
    logic [4:0] lo;
    logic [7:0] bb;
    logic [7:0] r;
    logic       ci;
    ci = (op == ALU_SUB);
    bb = ci ? ~b : b;
    sum = {1'b0, a} + {1'b0, bb} + 9'(ci);
    lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(ci);
    r = sum[7:0];
    if (op == ALU_ADD || op == ALU_SUB) begin
      s[BIT_C] = sum[8];
      s[BIT_DC] = lo[4];
      s[BIT_OV] = (a[7] == bb[7]) && (r[7] != a[7]);
    end
    if (op == ALU_LOGIC) r = a;
    if (op == ALU_RLC) begin
      r = {a[6:0], s[BIT_C]};
      s[BIT_C] = a[7];
    end
    if (op == ALU_RRC) begin
      r = {s[BIT_C], a[7:1]};
      s[BIT_C] = a[0];
    end
    if (op != ALU_NONE) begin
      s[BIT_N] = r[7];
      s[BIT_Z] = (r == 8'h00);
    end
    if (wt) s[BIT_TO] = 1'b0;
    else if (cw || sl) s[BIT_TO] = 1'b1;
    if (sl) s[BIT_PD] = 1'b0;
    else if (cw) s[BIT_PD] = 1'b1;
    return s;
  endfunction

  // one-cycle register write
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // one-cycle read, data taken in the following cycle only
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  // one cycle of core events, status model follows
  task automatic ev(input logic r, cw, sl, wt, input alu_op_e op, input logic [7:0] a, b);
    @(posedge clk_i);
    {ret_i, watchdog_clear_instr_i, sleep_i, wdt_timeout_i} <= {r, cw, sl, wt};
    alu_op_i <= op;
    alu_a_i <= a;
    alu_b_i <= b;
    @(posedge clk_i);
    {ret_i, watchdog_clear_instr_i, sleep_i, wdt_timeout_i} <= 4'h0;
    alu_op_i <= ALU_NONE;
    #1;
    st = nxt(st, cw, sl, wt, op, a, b);
    `CHK("status", st, status_o)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic do_reset();
    nrst_i <= 1'b0;
    idle(8);
    nrst_i <= 1'b1;
    st = STATUS_RST;
    `CHK("status rst", 8'h60, status_o)
    `CHK("pc rst", 21'h0, pc_o)
    `CHK("tos rst", 21'h0, tos_o)
    `CHK("sp rst", 5'h0, stack_location_pointer_o)
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run of about 370 cycles
  initial begin
    #(40 * 30000);
    n_errors++;
    end_sim();
  end

  initial begin
    do_reset();
    // reset values through the bus, unmapped places read zero
    foreach (OFS_INDF[i]) begin
      rd(OFS_PTR_LO[i], d);
      `CHK("ptr rst", 8'h00, d)
    end
    rd(OFS_PCL, d);
    `CHK("pcl rst", 8'h00, d)
    rd(OFS_TOS_U, d);
    `CHK("stack_top_upper_field rst", 8'h00, d)
    wr(12'hFF0, 8'h55);
    rd(12'hFF0, d);
    `CHK("unmapped", 8'h00, d)
    rd(12'hFDB, d);
    `CHK("offset reg", 8'h00, d)
    // working shadow read/write
    rs = xs(rs);
    wr(OFS_WORKING_REG_SHADOW, rs[7:0]);
    rd(OFS_WORKING_REG_SHADOW, d);
    `CHK("working_reg_shadow", rs[7:0], d)
    // counter load from latches plus written low byte
    rs = xs(rs);
    wr(OFS_PROG_COUNTER_LATCHES_H, rs[12:8]);
    wr(OFS_PROG_COUNTER_LATCHES_L, rs[7:0]);
    wr(OFS_PCL, rs[23:16]);
    `CHK("pc load", {rs[12:0], rs[23:16]}, pc_o)
    rd(OFS_PCL, d);
    `CHK("pcl", rs[23:16], d)
    // stack entries, including both ends of the pointer range
    for (int k = 0; k < 3; k++) begin
      rs = xs(rs);
      t = rs[20:0];
      w = (k == 0) ? 8'h00 : (k == 1) ? 8'h1F : {3'b0, rs[25:22], 1'b1};
      if (k == 0) t0 = t;
      wr(OFS_STACK_LOCATION_POINTER, w);
      wr(OFS_TOS_L, t[7:0]);
      wr(OFS_TOS_H, t[15:8]);
      wr(OFS_TOS_U, {3'b0, t[20:16]});
      idle(2);
      `CHK("sp", w[4:0], stack_location_pointer_o)
      `CHK("tos", t, tos_o)
      rd(OFS_TOS_H, d);
      `CHK("stack_top_high_byte", t[15:8], d)
      rd(OFS_TOS_U, d);
      `CHK("stack_top_upper_field", {3'b0, t[20:16]}, d)
      // overwrite the high latch so that a read of the low byte must refresh it
      wr(OFS_PROG_COUNTER_LATCHES_L, ~t[15:8]);
      ev(1'b1, 1'b0, 1'b0, 1'b0, ALU_NONE, 8'h00, 8'h00);
      `CHK("ret pc", t, pc_o)
      rd(OFS_PCL, d);
      `CHK("pcl ret", t[7:0], d)
      rd(OFS_PROG_COUNTER_LATCHES_L, d);
      `CHK("high latch", t[15:8], d)
      rd(OFS_PROG_COUNTER_LATCHES_H, d);
      `CHK("upper latch", {3'b0, t[20:16]}, d)
    end
    wr(OFS_STACK_LOCATION_POINTER, 8'h00);
    idle(2);
    `CHK("tos kept", t0, tos_o)
    // write then read of the low stack byte with no gap between strobes
    rs = xs(rs);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= OFS_TOS_L;
    wdata_i <= rs[7:0];
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK("stack_top_low_byte b2b", rs[7:0], rdata_o)
    t0[7:0] = rs[7:0];
    // arithmetic corners, then random operations
    ev(1'b0, 1'b0, 1'b0, 1'b0, ALU_ADD, 8'h7F, 8'h01);
    ev(1'b0, 1'b0, 1'b0, 1'b0, ALU_ADD, 8'hFF, 8'h01);
    ev(1'b0, 1'b0, 1'b0, 1'b0, ALU_SUB, 8'h00, 8'h01);
    ev(1'b0, 1'b0, 1'b0, 1'b0, ALU_SUB, 8'h80, 8'h01);
    ev(1'b0, 1'b0, 1'b0, 1'b0, ALU_LOGIC, 8'h00, 8'h00);
    for (int k = 0; k < 60; k++) begin
      rs = xs(rs);
      ev(1'b0, 1'b0, 1'b0, 1'b0, ops[rs[26:24] % 5], rs[7:0], rs[15:8]);
    end
    // time-out and power-down flag events
    ev(1'b0, 1'b0, 1'b0, 1'b1, ALU_NONE, 8'h00, 8'h00);
    ev(1'b0, 1'b1, 1'b0, 1'b0, ALU_NONE, 8'h00, 8'h00);
    ev(1'b0, 1'b0, 1'b1, 1'b0, ALU_NONE, 8'h00, 8'h00);
    ev(1'b0, 1'b0, 1'b0, 1'b1, ALU_NONE, 8'h00, 8'h00);
    // software write reaches only the arithmetic flags
    wr(OFS_STATUS, 8'hFF);
    st = {1'b0, st[6:5], 5'h1F};
    rd(OFS_STATUS, d);
    `CHK("status wr", st, d)
    // indirect channels aimed at the working shadow
    foreach (OFS_INDF[c]) begin
      rs = xs(rs);
      wr(OFS_PTR_LO[c], 8'hE8);
      wr(OFS_PTR_HI[c], 8'h0F);
      wr(OFS_WORKING_REG_SHADOW, rs[7:0]);
      rd(OFS_INDF[c], d);
      `CHK("indf rd", rs[7:0], d)
      wr(OFS_INDF[c], rs[15:8]);
      `CHK("indf wr", rs[15:8], working_reg_shadow_o)
      rd(OFS_PTR_LO[c], d);
      `CHK("ptr kept", 8'hE8, d)
      rd(OFS_POSTINC[c], d);
      `CHK("postinc rd", rs[15:8], d)
      rd(OFS_PTR_LO[c], d);
      `CHK("ptr inc", 8'hE9, d)
      wr(OFS_PTR_LO[c], 8'hE8);
      wr(OFS_POSTDEC[c], rs[23:16]);
      `CHK("postdec wr", rs[23:16], working_reg_shadow_o)
      rd(OFS_PTR_LO[c], d);
      `CHK("ptr dec", 8'hE7, d)
      // wrap both ways across the 12-bit range
      wr(OFS_PTR_LO[c], 8'hFF);
      rd(OFS_POSTINC[c], d);
      rd(OFS_PTR_HI[c], d);
      `CHK("wrap up hi", 8'h00, d)
      rd(OFS_POSTDEC[c], d);
      `CHK("addr 000", 8'h00, d)
      rd(OFS_PTR_HI[c], d);
      `CHK("wrap dn hi", 8'h0F, d)
      rd(OFS_PTR_LO[c], d);
      `CHK("wrap dn lo", 8'hFF, d)
    end
    // other reset keeps flags and shadow, clears counter and pointers
    w = working_reg_shadow_o;
    @(posedge clk_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    #1;
    `CHK("soft status", st, status_o)
    `CHK("soft working_reg_shadow", w, working_reg_shadow_o)
    `CHK("soft pc", 21'h0, pc_o)
    `CHK("soft sp", 5'h0, stack_location_pointer_o)
    // power-on reset in mid-run
    do_reset();
    end_sim();
  end
endmodule
`undef CHK
`default_nettype wire
